// File: design/rsp_regs.vh
// Constants for the radio serial register port
`ifndef RSP_REGS_VH
`define RSP_REGS_VH
`define RSP_ADDR_W 7
`define RSP_DATA_W 8
`define RSP_REG_COUNT 128
`define RSP_REG_RESET 8'h00
`define RSP_DIR_WRITE 1'b1
`define RSP_BYTE_BITS 4'h8
`define RSP_SCLK_MAX_MHZ 10
`define RSP_CORE_MHZ 50
`define RSP_SCLK_MIN_CYC (`RSP_CORE_MHZ / `RSP_SCLK_MAX_MHZ)
`endif

// File: design/rsp_spi_port.v
// Serial register port with 128 eight-bit registers
`timescale 1ns/100ps
`include "rsp_regs.vh"
// Function
// [R1] Frame is direction, address, then data byte
// [R2] Seven address bits then eight data bits
// [R3] Direction one writes, zero reads
// [R4] Address selects one of 128 registers
// [R5] Bytes captured after each eight clocks
// [R6] Host keeps serial clock at most 10 MHz
// [R7] Data input ignored during read data
// [R8] Read data shifted out on falling edges
// [R9] Output holds last data bit afterwards; code shifts out the next register's MSB on the following falling edge
// [R10] Select high releases output to pull-up
// [R11] Continued clocking advances address by one
// [R12] Burst write takes byte every eight clocks
// [R13] Shutdown disables port and clears registers
// [R14] Modes selected through register writes
// [R15] Select falls to start, rising samples MSB
// [R16] Early select rise aborts partial byte
module rsp_spi_port #(
  parameter ADDR_W = `RSP_ADDR_W,
  parameter DATA_W = `RSP_DATA_W,
  parameter REG_COUNT = `RSP_REG_COUNT
) (
  input wire I_CORE_CLK,
  input wire I_SYS_RST,
  input wire i_clk_en,
  input wire i_shutdown,
  input wire i_sclk,
  input wire i_sdi,
  input wire i_chip_select_low,
  output wire o_sdo,
  output wire o_sdo_oe,
  output wire [DATA_W-1:0] o_mode_reg,
  output wire o_busy
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam PIN_N = 4;
  localparam PIN_SCLK = 0;
  localparam PIN_SDI = 1;
  localparam PIN_CSL = 2;
  localparam PIN_SDN = 3;

  wire [PIN_N-1:0] pin_raw;
  wire [PIN_N-1:0] pin_idle;
  wire [PIN_N-1:0] pin_sync;

  assign pin_raw = {i_shutdown, i_chip_select_low, i_sdi, i_sclk};

  // Reset to idle levels so no false edge follows reset
  assign pin_idle = 4'h4;

  genvar pi;
  generate
    for (pi = 0; pi < PIN_N; pi = pi + 1) begin : g_sync
      reg meta_q;
      reg sync_q;

      always @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
          meta_q <= pin_idle[pi];
          sync_q <= pin_idle[pi];
        end else if (i_clk_en) begin
          meta_q <= pin_raw[pi];
          sync_q <= meta_q;
        end
      end

      assign pin_sync[pi] = sync_q;
    end
  endgenerate

  // ****************************************
  // Edge detection
  // ****************************************
  reg sclk_prev_q;
  reg csl_prev_q;

  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      sclk_prev_q <= 1'b0;
      csl_prev_q <= 1'b1;
    end else if (i_clk_en) begin
      sclk_prev_q <= pin_sync[PIN_SCLK];
      csl_prev_q <= pin_sync[PIN_CSL];
    end
  end

  wire sclk_rise;
  wire sclk_fall;
  wire sel_active;
  wire sel_fall;
  wire sdi_bit;
  wire port_on;

  assign sclk_rise = pin_sync[PIN_SCLK] & ~sclk_prev_q;
  assign sclk_fall = ~pin_sync[PIN_SCLK] & sclk_prev_q;
  assign sel_active = ~pin_sync[PIN_CSL];
  assign sel_fall = ~pin_sync[PIN_CSL] & csl_prev_q;
  assign sdi_bit = pin_sync[PIN_SDI];
  assign port_on = ~pin_sync[PIN_SDN]; // [R13]

  // ****************************************
  // Frame decoder
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] bit_cnt_q;
  reg [3:0] bit_cnt_d;
  reg [7:0] shift_in_q;
  reg [7:0] shift_in_d;
  reg [ADDR_W-1:0] addr_q;
  reg [ADDR_W-1:0] addr_d;
  reg write_q;
  reg write_d;
  reg wr_en;
  reg load_out;

  wire [7:0] byte_now;
  wire byte_done;
  wire frame_stop;
  wire bit_take;

  assign byte_now = {shift_in_q[6:0], sdi_bit};

  // Eighth rising edge of the current unit
  assign byte_done = (bit_cnt_q == `RSP_BYTE_BITS - 4'h1);

  // Deselect or shutdown drops any partial byte
  assign frame_stop = ~sel_active | ~port_on;

  assign bit_take = ~frame_stop & ~sel_fall & sclk_rise &
    (state_q != ST_IDLE);

  // ****************************************
  // Frame position
  // ****************************************
  always @* begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    if (frame_stop) begin
      state_d = ST_IDLE; // [R16] [R10]
      bit_cnt_d = 4'h0;
    end else if (sel_fall) begin
      state_d = ST_ADDR; // [R15]
      bit_cnt_d = 4'h0;
    end else if (bit_take) begin
      bit_cnt_d = bit_cnt_q + 4'h1;
      if (byte_done) begin
        bit_cnt_d = 4'h0; // [R5]
        case (state_q)
          ST_ADDR: state_d = ST_DATA;
          ST_DATA: state_d = ST_DATA;
          default: state_d = ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Byte capture
  // ****************************************
  always @* begin
    shift_in_d = shift_in_q;
    addr_d = addr_q;
    write_d = write_q;
    wr_en = 1'b0;
    load_out = 1'b0;
    if (bit_take) begin
      shift_in_d = byte_now; // [R15] MSB first on rising edge
      if (byte_done && state_q == ST_ADDR) begin
        write_d = (byte_now[7] == `RSP_DIR_WRITE); // [R1] [R3]
        addr_d = byte_now[ADDR_W-1:0]; // [R2] [R4]
        load_out = ~byte_now[7];
      end else if (byte_done) begin
        wr_en = write_q; // [R12] [R14]; reads drop input [R7]
        addr_d = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R11]
        load_out = ~write_q;
      end
    end
  end

  // ****************************************
  // Decoder registers
  // ****************************************
  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      shift_in_q <= 8'h00;
      addr_q <= {ADDR_W{1'b0}};
      write_q <= 1'b0;
    end else if (i_clk_en) begin
      shift_in_q <= shift_in_d;
      addr_q <= addr_d;
      write_q <= write_d;
    end
  end

  // ****************************************
  // Register space
  // ****************************************
  reg [DATA_W-1:0] mem_q [0:REG_COUNT-1];
  wire [DATA_W-1:0] wr_data;

  assign wr_data = shift_in_d;

  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi = gi + 1) begin : g_reg
      always @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
          mem_q[gi] <= `RSP_REG_RESET;
        end else if (i_clk_en) begin
          if (!port_on) begin
            mem_q[gi] <= `RSP_REG_RESET; // [R13]
          end else if (wr_en && addr_q == gi) begin
            mem_q[gi] <= wr_data; // [R4]
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data output
  // ****************************************
  reg [7:0] shift_out_q;
  reg sdo_q;
  reg sdo_oe_q;

  wire [ADDR_W-1:0] rd_addr;
  wire out_shift;

  // Address byte in flight gives the first read address
  assign rd_addr = (state_q == ST_ADDR) ? byte_now[ADDR_W-1:0] : addr_d;

  assign out_shift = sclk_fall & (state_q == ST_DATA) & ~write_q;

  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      shift_out_q <= 8'h00;
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else if (i_clk_en) begin
      if (frame_stop) begin
        sdo_q <= 1'b1; // [R10]
        sdo_oe_q <= 1'b0;
      end else if (load_out) begin
        shift_out_q <= mem_q[rd_addr]; // [R8] [R11]
      end else if (out_shift) begin
        sdo_q <= shift_out_q[7]; // [R8]
        shift_out_q <= {shift_out_q[6:0], shift_out_q[7]};
        sdo_oe_q <= 1'b1; // [R9] stays driving last bit
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_sdo = sdo_q;
  assign o_sdo_oe = sdo_oe_q;
  assign o_mode_reg = mem_q[7];
  assign o_busy = (state_q != ST_IDLE);

endmodule

// File: test/radio_spi_register_port_bench.sv
// Self-checking bench for the serial port
`timescale 1ns/100ps
module radio_spi_register_port_bench;
  reg clk = 0, rst = 1, en = 1, shut = 0;
  wire sclk, sdi, csl, sdo, oe, busy;
  wire [7:0] mode;
  wire line = oe ? sdo : 1'b1;
  int bad_count = 0, total_checks = 0, cyc = 0;
  reg [7:0] r0, r1;
  always #10 clk = ~clk;
  rsp_spi_port dut(.I_CORE_CLK(clk), .I_SYS_RST(rst), .i_clk_en(en),
    .i_shutdown(shut), .i_sclk(sclk), .i_sdi(sdi),
    .i_chip_select_low(csl), .o_sdo(sdo), .o_sdo_oe(oe),
    .o_mode_reg(mode), .o_busy(busy));
  rsp_host_model host(.sdo_line(line), .sclk(sclk), .sdi(sdi),
    .chip_select_low(csl));
  task chk(input string n, input [7:0] e, s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task frame(input [7:0] h, d0, d1, input int nb);
    @(posedge clk);
    #2 host.start;
    host.xfer(8, h, r0);
    host.xfer(8, d0, r0);
    if (nb > 1) host.xfer(8, d1, r1);
    host.stop;
  endtask
  task tally_and_finish;
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task t_single;
    frame(8'h87, 8'h5A, 8'h00, 1);
    chk("mode", 8'h5A, mode);
    frame(8'h07, 8'hFF, 8'h00, 1);
    chk("read", 8'h5A, r0);
    chk("mode", 8'h5A, mode);
    chk("oe", 8'h00, {7'h00, oe});
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task t_burst;
    frame(8'h86, 8'hA1, 8'hC3, 2);
    chk("mode", 8'hC3, mode);
    frame(8'h06, 8'h00, 8'h00, 2);
    chk("rd6", 8'hA1, r0);
    chk("rd7", 8'hC3, r1);
  endtask
  task t_abort;
    @(posedge clk);
    #2 host.start;
    host.xfer(8, 8'h87, r0);
    host.xfer(4, 8'hF0, r0);
    host.stop;
    chk("mode", 8'hC3, mode);
    frame(8'h87, 8'h3C, 8'h00, 1);
    chk("mode", 8'h3C, mode);
  endtask
  task t_shut;
    @(posedge clk) #2 en = 0;
    repeat (5) @(posedge clk);
    #2 en = 1;
    chk("mode", 8'h3C, mode);
    shut = 1;
    repeat (5) @(posedge clk);
    #2 chk("mode", 8'h00, mode);
    frame(8'h87, 8'h77, 8'h00, 1);
    chk("mode", 8'h00, mode);
    @(posedge clk) #2 shut = 0;
    repeat (5) @(posedge clk);
    frame(8'h06, 8'h00, 8'h00, 1);
    chk("rd6", 8'h00, r0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #2 rst = 0;
    repeat (5) @(posedge clk);
    t_single;
    t_burst;
    t_abort;
    t_shut;
    tally_and_finish;
  end
endmodule

// File: test/rsp_host_model.sv
// Host controller model for the serial port
`timescale 1ns/100ps
module rsp_host_model(input wire sdo_line, output reg sclk = 0,
  output reg sdi = 1, output reg chip_select_low = 1);
  task start;
    chip_select_low = 0;
    #80;
  endtask
  task stop;
    #80 chip_select_low = 1;
    sdi = ~sdi;
    #200;
  endtask
  task xfer(input int n, input [7:0] tx, output [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      sdi = tx[i];
      #80 sclk = 1;
      #79 rx[i] = sdo_line;
      #1 sclk = 0;
    end
  endtask
endmodule

// File: test/rsp_spi_port_props.sv
// Assertions on the serial port pins
`timescale 1ns/100ps
module rsp_port_props(input wire I_CORE_CLK, I_SYS_RST, i_clk_en,
  i_shutdown, i_sclk, i_sdi, i_chip_select_low, o_sdo, o_sdo_oe,
  o_busy, input wire [7:0] o_mode_reg);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_release_high: assert property (
    !o_sdo_oe |-> o_sdo) else $error("sdo low when free");
  a_deselect_off: assert property (
    i_chip_select_low[*8] |-> !o_sdo_oe) else $error("oe stuck");
  a_deselect_idle: assert property (
    i_chip_select_low[*8] |-> !o_busy) else $error("busy stuck");
  a_shut_clear: assert property (
    i_shutdown[*4] |-> o_mode_reg == 8'h00) else $error("mode kept");
  a_shut_silent: assert property (
    i_shutdown[*4] |-> !o_sdo_oe && !o_busy) else $error("shut active");
  a_frame_start: assert property (
    $rose(o_busy) |-> !$past(i_chip_select_low)) else $error("bad start");
  a_drive_in_frame: assert property (
    $rose(o_sdo_oe) |-> o_busy && !i_chip_select_low) else $error("oe");
  a_freeze_hold: assert property (
    !i_clk_en |=> $stable(o_mode_reg)) else $error("mode moved");
endmodule
bind rsp_spi_port rsp_port_props chk_i (.*);
